// [src/vec_alu_defs.svh]
`ifndef VEC_ALU_DEFS_SVH
`define VEC_ALU_DEFS_SVH

// operation codes
`define OP_ADD 5'h00
`define OP_SUB 5'h01
`define OP_ADDC 5'h02
`define OP_SUBC 5'h03
`define OP_AVG 5'h04
`define OP_MAX 5'h05
`define OP_MIN 5'h06
`define OP_CMPEQ 5'h07
`define OP_CMPGT 5'h08
`define OP_AND 5'h09
`define OP_OR 5'h0a
`define OP_XOR 5'h0b
`define OP_ANDC 5'h0c
`define OP_NOR 5'h0d
`define OP_RL 5'h0e
`define OP_SL 5'h0f
`define OP_SR 5'h10
`define OP_SRA 5'h11
`define OP_MULE 5'h12
`define OP_MULO 5'h13
`define OP_MHADD 5'h14
`define OP_MHRADD 5'h15
`define OP_MLADD 5'h16
`define OP_MSUM 5'h17
`define OP_SUMS 5'h18
`define OP_SUM2S 5'h19
`define OP_SUM4S 5'h1a

// element sizes
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2

// compare summary field values, bit 0 at the left
`define SUM_ALL_TRUE 4'h8
`define SUM_ALL_FALSE 4'h2

// multiply-high scaling
`define MH_SHIFT 15
`define MH_ROUND 40'sh0000004000

`endif

// [src/vec_alu_pkg.sv]
package vec_alu_pkg;

  typedef logic [4:0] op_type;
  typedef logic [1:0] size_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } state_type;

  typedef struct packed {
    logic valid;
    op_type op;
    size_type size;
    logic uns;
    logic sat;
    logic rec;
    logic [4:0] dest;
    logic [1:0] addr_lo;
    logic [127:0] va;
    logic [127:0] vb;
    logic [127:0] vc;
  } vec_req_type;

  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [127:0] data;
  } vec_wb_type;

  typedef struct packed {
    logic we;
    logic [0:3] field;
  } cr_upd_type;

  function automatic logic [31:0] mask_f(input int w);
    return 32'hffff_ffff >> (32 - w);
  endfunction : mask_f

  function automatic logic signed [39:0] sx_f(input logic [31:0] x, input int w,
                                              input logic uns);
    logic [39:0] v;
    v = {8'h00, x} & ((40'h1 << w) - 40'h1);
    if (!uns && v[w-1]) begin
      v = v - (40'h1 << w);
    end
    return $signed(v);
  endfunction : sx_f

  function automatic logic [31:0] sat_f(input logic signed [39:0] v, input int w,
                                        input logic uns);
    logic signed [39:0] hi;
    logic signed [39:0] lo;
    logic [31:0] r;
    hi = uns ? (40'sh1 <<< w) - 40'sh1 : (40'sh1 <<< (w - 1)) - 40'sh1;
    lo = uns ? 40'sh0 : -hi - 40'sh1;
    if (v > hi) begin
      r = hi[31:0];
    end else if (v < lo) begin
      r = lo[31:0];
    end else begin
      r = v[31:0];
    end
    return r & mask_f(w);
  endfunction : sat_f

endpackage : vec_alu_pkg

// [src/vec_lane.sv]
`include "vec_alu_defs.svh"

module vec_lane (
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  input wire vec_alu_pkg::op_type op_i,
  input wire vec_alu_pkg::size_type size_i,
  input wire logic uns_i,
  input wire logic sat_i,
  output logic [31:0] res_o
);
  import vec_alu_pkg::*;

  function automatic logic [31:0] elem_f(input logic [31:0] a, input logic [31:0] b,
                                         input int w);
    logic signed [39:0] ea;
    logic signed [39:0] eb;
    logic signed [39:0] s;
    logic signed [39:0] t;
    logic [31:0] x;
    logic [31:0] m;
    logic [31:0] r;
    int sh;
    m = mask_f(w);
    x = a & m;
    ea = sx_f(a, w, uns_i);
    eb = sx_f(b, w, uns_i);
    s = ea + eb;
    sh = int'(b & 32'(w - 1));
    t = '0;
    r = '0;
    case (op_i)
      `OP_ADD: begin
        r = sat_i ? sat_f(s, w, uns_i) : s[31:0];
      end
      `OP_SUB: begin
        t = ea - eb;
        r = sat_i ? sat_f(t, w, uns_i) : t[31:0];
      end
      `OP_ADDC: r = {31'h0, s[w]};
      `OP_SUBC: r = {31'h0, ea >= eb};
      `OP_AVG: begin
        t = (s + 40'sd1) >>> 1;
        r = t[31:0];
      end
      `OP_MAX: r = (ea > eb) ? a : b;
      `OP_MIN: r = (ea < eb) ? a : b;
      `OP_CMPEQ: r = (ea == eb) ? m : 32'h0;
      `OP_CMPGT: r = (ea > eb) ? m : 32'h0;
      `OP_RL: r = (x << sh) | (x >> (w - sh));
      `OP_SL: r = x << sh;
      `OP_SR: r = x >> sh;
      `OP_SRA: begin
        t = ea >>> sh;
        r = t[31:0];
      end
      default: r = '0;
    endcase
    return r & m;
  endfunction : elem_f

  always_comb begin
    int w;
    int n;
    logic [31:0] t;
    w = 8 << size_i;
    n = 4 >> size_i;
    t = '0;
    res_o = '0;
    for (int k = 0; k < 4; k++) begin
      if (k < n) begin
        t = elem_f(a_i >> (k * w), b_i >> (k * w), w);
        res_o = res_o | (t << (k * w));
      end
    end
  end

endmodule : vec_lane

// [src/vec_int_alu.sv]
`include "vec_alu_defs.svh"

module vec_int_alu (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire vec_alu_pkg::vec_req_type req_i,
  input wire logic le_mode_i,
  output logic ready_o,
  output vec_alu_pkg::vec_wb_type wb_o,
  output vec_alu_pkg::cr_upd_type cr_o,
  output logic fault_o
);
  import vec_alu_pkg::*;

  state_type st_q;
  state_type st_d;
  vec_req_type req_q;
  vec_wb_type wb_q;
  vec_wb_type wb_d;
  cr_upd_type cr_q;
  cr_upd_type cr_d;
  logic le_q;
  logic ready_q;
  logic fault_q;
  logic [127:0] lane_res;
  logic [127:0] cx_res;

  // a request is taken only in idle, so one op is in flight at a time
  wire take_w = (st_q == ST_IDLE) && req_i.valid;
  wire exec_w = (st_q == ST_EXEC);
  wire misalign_w = (req_q.addr_lo != 2'h0);
  wire bad_op_w = (req_q.op > `OP_SUM4S) || (req_q.size > `SZ_WORD);
  wire bad_w = misalign_w || bad_op_w;
  wire use_lane_w = (req_q.op <= `OP_SRA) && (req_q.op < `OP_AND || req_q.op > `OP_NOR);
  wire is_cmp_w = (req_q.op == `OP_CMPEQ) || (req_q.op == `OP_CMPGT);
  wire [127:0] res_w = use_lane_w ? lane_res : cx_res;
  wire all_t_w = &res_w;
  wire all_f_w = ~|res_w;
  wire [0:3] sum_w = {all_t_w, 1'b0, all_f_w, 1'b0};

  // element numbering mirrors in little-endian mode
  function automatic int off_f(input int j, input int n, input int w);
    return le_q ? j * w : (n - 1 - j) * w;
  endfunction : off_f

  function automatic logic [31:0] get_f(input logic [127:0] v, input int j,
                                        input int n, input int w);
    logic [127:0] s;
    s = v >> off_f(j, n, w);
    return s[31:0] & mask_f(w);
  endfunction : get_f

  function automatic logic [127:0] put_f(input logic [31:0] x, input int j,
                                         input int n, input int w);
    logic [127:0] e;
    e = {96'h0, x & mask_f(w)};
    return e << off_f(j, n, w);
  endfunction : put_f

  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    vec_lane u_lane (
      .a_i(req_q.va[32*g +: 32]),
      .b_i(req_q.vb[32*g +: 32]),
      .op_i(req_q.op),
      .size_i(req_q.size),
      .uns_i(req_q.uns),
      .sat_i(req_q.sat),
      .res_o(lane_res[32*g +: 32])
    );
  end

  always_comb begin : cx_blk
    int n;
    int w;
    int j;
    logic signed [39:0] pa;
    logic signed [39:0] pb;
    logic signed [39:0] pc;
    logic signed [39:0] acc;
    n = 0;
    w = 8 << req_q.size;
    j = 0;
    pa = '0;
    pb = '0;
    pc = '0;
    acc = '0;
    cx_res = '0;
    case (req_q.op)
      `OP_AND: cx_res = req_q.va & req_q.vb;
      `OP_OR: cx_res = req_q.va | req_q.vb;
      `OP_XOR: cx_res = req_q.va ^ req_q.vb;
      `OP_ANDC: cx_res = req_q.va & ~req_q.vb;
      `OP_NOR: cx_res = ~(req_q.va | req_q.vb);
      `OP_MULE, `OP_MULO: begin
        n = 64 / w;
        for (int k = 0; k < 8; k++) begin
          if (k < n) begin
            j = 2 * k + int'(req_q.op == `OP_MULO);
            pa = sx_f(get_f(req_q.va, j, 2 * n, w), w, req_q.uns);
            pb = sx_f(get_f(req_q.vb, j, 2 * n, w), w, req_q.uns);
            acc = pa * pb;
            cx_res = cx_res | put_f(acc[31:0], k, n, 2 * w);
          end
        end
      end
      `OP_MHADD, `OP_MHRADD: begin
        for (int k = 0; k < 8; k++) begin
          pa = sx_f(get_f(req_q.va, k, 8, 16), 16, 1'b0);
          pb = sx_f(get_f(req_q.vb, k, 8, 16), 16, 1'b0);
          pc = sx_f(get_f(req_q.vc, k, 8, 16), 16, 1'b0);
          acc = pa * pb;
          if (req_q.op == `OP_MHRADD) begin
            acc = acc + `MH_ROUND;
          end
          acc = (acc >>> `MH_SHIFT) + pc;
          cx_res = cx_res | put_f(sat_f(acc, 16, 1'b0), k, 8, 16);
        end
      end
      `OP_MLADD: begin
        for (int k = 0; k < 8; k++) begin
          pa = sx_f(get_f(req_q.va, k, 8, 16), 16, 1'b1);
          pb = sx_f(get_f(req_q.vb, k, 8, 16), 16, 1'b1);
          pc = sx_f(get_f(req_q.vc, k, 8, 16), 16, 1'b1);
          acc = pa * pb + pc;
          cx_res = cx_res | put_f(acc[31:0], k, 8, 16);
        end
      end
      `OP_MSUM: begin
        n = 32 / w;
        for (int k = 0; k < 4; k++) begin
          acc = sx_f(get_f(req_q.vc, k, 4, 32), 32, req_q.uns);
          for (int i = 0; i < 4; i++) begin
            if (i < n) begin
              j = k * n + i;
              pa = sx_f(get_f(req_q.va, j, 4 * n, w), w, req_q.uns);
              // signed byte form is mixed: second source stays unsigned
              pb = sx_f(get_f(req_q.vb, j, 4 * n, w), w, req_q.uns || (w == 8));
              acc = acc + pa * pb;
            end
          end
          if (req_q.sat) begin
            cx_res = cx_res | put_f(sat_f(acc, 32, req_q.uns), k, 4, 32);
          end else begin
            cx_res = cx_res | put_f(acc[31:0], k, 4, 32);
          end
        end
      end
      `OP_SUMS: begin
        acc = sx_f(get_f(req_q.vb, 3, 4, 32), 32, 1'b0);
        for (int k = 0; k < 4; k++) begin
          acc = acc + sx_f(get_f(req_q.va, k, 4, 32), 32, 1'b0);
        end
        cx_res = put_f(sat_f(acc, 32, 1'b0), 3, 4, 32);
      end
      `OP_SUM2S: begin
        for (int k = 1; k < 4; k = k + 2) begin
          acc = sx_f(get_f(req_q.vb, k, 4, 32), 32, 1'b0);
          acc = acc + sx_f(get_f(req_q.va, k - 1, 4, 32), 32, 1'b0);
          acc = acc + sx_f(get_f(req_q.va, k, 4, 32), 32, 1'b0);
          cx_res = cx_res | put_f(sat_f(acc, 32, 1'b0), k, 4, 32);
        end
      end
      `OP_SUM4S: begin
        n = 32 / w;
        for (int k = 0; k < 4; k++) begin
          acc = sx_f(get_f(req_q.vb, k, 4, 32), 32, req_q.uns);
          for (int i = 0; i < 4; i++) begin
            if (i < n) begin
              acc = acc + sx_f(get_f(req_q.va, k * n + i, 4 * n, w), w, req_q.uns);
            end
          end
          cx_res = cx_res | put_f(sat_f(acc, 32, req_q.uns), k, 4, 32);
        end
      end
      default: cx_res = '0;
    endcase
  end

  always_comb begin
    case (st_q)
      ST_IDLE: st_d = req_i.valid ? ST_EXEC : ST_IDLE;
      ST_EXEC: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // results return only to the register file port; there is no memory port
  assign wb_d = '{valid: exec_w && !bad_w, dest: req_q.dest, data: res_w};
  // summary field written only on a recorded compare
  assign cr_d = '{we: exec_w && !bad_w && is_cmp_w && req_q.rec, field: sum_w};

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= ST_IDLE;
      req_q <= '0;
      le_q <= 1'b0;
      ready_q <= 1'b1;
      fault_q <= 1'b0;
      wb_q <= '0;
      cr_q <= '0;
    end else begin
      st_q <= st_d;
      ready_q <= (st_d == ST_IDLE);
      fault_q <= exec_w && bad_w;
      wb_q <= wb_d;
      cr_q <= cr_d;
      if (take_w) begin
        req_q <= req_i;
        le_q <= le_mode_i;
      end
    end
  end

  assign ready_o = ready_q;
  assign wb_o = wb_q;
  assign cr_o = cr_q;
  assign fault_o = fault_q;

  // assertion helpers
  function automatic logic word_mask_f(input logic [127:0] d);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 4; k++) begin
      ok = ok && ((d[32*k +: 32] == 32'h0) || (d[32*k +: 32] == 32'hffff_ffff));
    end
    return ok;
  endfunction : word_mask_f

  wire good_req_w = req_i.addr_lo == 2'h0 && req_i.op <= `OP_SUM4S && req_i.size <= `SZ_WORD;
  wire wb_cmp_w = wb_o.valid && (req_q.op == `OP_CMPEQ || req_q.op == `OP_CMPGT);

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence seq_take_good;
    take_w && good_req_w;
  endsequence

  sequence seq_exec_wb;
    !ready_o ##1 wb_o.valid && ready_o;
  endsequence

  property p_wb_after_take;
    seq_take_good |=> seq_exec_wb;
  endproperty

  a_wb_two_cycles: assert property (p_wb_after_take)
    else $error("write-back did not follow an accepted request");

  a_misalign_fault: assert property (take_w && req_i.addr_lo != 2'h0 |-> ##2 fault_o && !wb_o.valid)
    else $error("misaligned opcode not refused");

  a_cr_only_rec: assert property (cr_o.we |-> wb_cmp_w && req_q.rec)
    else $error("summary field written without record bit");

  a_cr_rec_update: assert property (wb_cmp_w && req_q.rec |-> cr_o.we)
    else $error("recorded compare did not update summary field");

  a_cr_all_true: assert property (cr_o.we && (&wb_o.data) |-> cr_o.field == `SUM_ALL_TRUE)
    else $error("all-true compare gave wrong summary");

  a_cr_all_false: assert property (cr_o.we && wb_o.data == 128'h0 |-> cr_o.field == `SUM_ALL_FALSE)
    else $error("all-false compare gave wrong summary");

  a_cmp_word_mask: assert property (wb_cmp_w && req_q.size == `SZ_WORD |-> word_mask_f(wb_o.data))
    else $error("word compare element not all ones or zeros");

  a_logic_and: assert property (wb_o.valid && req_q.op == `OP_AND |-> wb_o.data == (req_q.va & req_q.vb))
    else $error("and result wrong");

  a_carry_bits: assert property (wb_o.valid && req_q.op == `OP_ADDC |-> (wb_o.data & ~{4{32'h1}}) == 128'h0)
    else $error("carry result has bits beyond bit 0 of a word");

endmodule : vec_int_alu

// [tb/issue_model.sv]
module issue_model import vec_alu_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ready_i,
  input wire logic start_i,
  input wire vec_alu_pkg::vec_req_type cmd_i,
  output vec_alu_pkg::vec_req_type req_o
);
  timeunit 1ns;
  timeprecision 1ns;

  vec_req_type req_q;

  // a request stands until the edge that takes it, like the issue stage
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_q <= '0;
    end else if (start_i) begin
      req_q <= cmd_i;
    end else if (req_q.valid && ready_i) begin
      // released operands are inverted so a late sample of stale data never matches
      req_q <= ~req_q;
    end
  end

  assign req_o = req_q;

endmodule : issue_model

// [tb/vector_integer_alu_tb.sv]
`include "vec_alu_defs.svh"

module vector_integer_alu_tb import vec_alu_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [127:0] nil = 128'h0;
  localparam logic [5:0] good = 6'h00;
  localparam logic [5:0] bad = 6'h20;

  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic le_mode = 1'b0;
  logic start = 1'b0;
  vec_req_type cmd = '0;
  vec_req_type req;
  logic ready;
  vec_wb_type wb;
  cr_upd_type cr;
  logic fault;
  int n_errors = 0;
  int samples_checked = 0;

  always #50 clock_i = ~clock_i;

  vec_int_alu i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req), .le_mode_i(le_mode),
    .ready_o(ready), .wb_o(wb), .cr_o(cr), .fault_o(fault));

  issue_model i_core (.clock_i(clock_i), .rst_b_i(rst_b_i), .ready_i(ready), .start_i(start),
    .cmd_i(cmd), .req_o(req));

  function automatic logic [127:0] rb(input logic [7:0] x);
    return {16{x}};
  endfunction : rb

  function automatic logic [127:0] rh(input logic [15:0] x);
    return {8{x}};
  endfunction : rh

  function automatic logic [127:0] rw(input logic [31:0] x);
    return {4{x}};
  endfunction : rw

  // usr packs the unsigned, saturate and record choices
  function automatic vec_req_type rq(input op_type op, input size_type sz,
                                     input logic [2:0] usr, input logic [127:0] a, b, c);
    return '{1'b1, op, sz, usr[2], usr[1], usr[0], 5'h0b, 2'h0, a, b, c};
  endfunction : rq

  task automatic wrap_up();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check

  // st = {fault, record pulse, summary field}
  task automatic run(input vec_req_type r, input logic [127:0] exp, input logic [5:0] st);
    int n;
    n = 0;
    start = 1'b1;
    cmd = r;
    @(posedge clock_i);
    #1;
    start = 1'b0;
    while (wb.valid !== 1'b1 && fault !== 1'b1 && n < 8) begin
      @(posedge clock_i);
      #1;
      n++;
      if (n == 1) check(ready === 1'b0, "ready high while busy");
    end
    if (wb.valid !== 1'b1 && fault !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t no answer", $time);
      wrap_up();
    end
    check(n == 2 && ready === 1'b1, "answer latency");
    check({fault, cr.we} === st[5:4], "fault or record pulse");
    if (st[4]) check(cr.field === st[3:0], "summary field");
    if (!st[5]) check(wb.data === exp && wb.dest === r.dest, "result");
    if (st[5]) check(wb.valid === 1'b0, "refused op wrote back");
    @(posedge clock_i);
    #1;
  endtask : run

  task automatic t_arith();
    run(rq(`OP_ADD, `SZ_BYTE, 3'b100, rb(8'h70), rb(8'h20), nil), rb(8'h90), good);
    run(rq(`OP_ADD, `SZ_BYTE, 3'b010, rb(8'h70), rb(8'h20), nil), rb(8'h7f), good);
    run(rq(`OP_ADD, `SZ_BYTE, 3'b110, rb(8'hf0), rb(8'h20), nil), rb(8'hff), good);
    run(rq(`OP_SUB, `SZ_HALF, 3'b110, rh(16'h1), rh(16'h2), nil), nil, good);
    run(rq(`OP_SUB, `SZ_WORD, 3'b010, rw(32'h8000_0000), rw(32'h1), nil),
        rw(32'h8000_0000), good);
    run(rq(`OP_SUB, `SZ_WORD, 3'b100, nil, rw(32'h1), nil), ~nil, good);
    run(rq(`OP_ADDC, `SZ_WORD, 3'b100, ~nil, {2{32'h1, 32'h0}}, nil),
        {2{32'h1, 32'h0}}, good);
    run(rq(`OP_SUBC, `SZ_WORD, 3'b100, {2{32'h5, 32'h4}}, rw(32'h5), nil),
        {2{32'h1, 32'h0}}, good);
  endtask : t_arith

  task automatic t_cmp();
    run(rq(`OP_CMPEQ, `SZ_WORD, 3'b001, rw(32'h1234_5678), rw(32'h1234_5678), nil),
        ~nil, 6'h18);
    run(rq(`OP_CMPGT, `SZ_BYTE, 3'b101, rb(8'h80), rb(8'h01), nil), ~nil, 6'h18);
    run(rq(`OP_CMPGT, `SZ_BYTE, 3'b001, rb(8'h80), rb(8'h01), nil), nil, 6'h12);
    run(rq(`OP_CMPGT, `SZ_HALF, 3'b001, {64'h0, {4{16'h5}}}, rh(16'h1), nil),
        {64'h0, {4{16'hffff}}}, 6'h10);
    run(rq(`OP_CMPEQ, `SZ_BYTE, 3'b000, nil, nil, nil), ~nil, good);
  endtask : t_cmp

  task automatic t_logic();
    logic [127:0] a;
    logic [127:0] b;
    a = rw(32'hff00_f0f0);
    b = rw(32'hf0f0_ff00);
    run(rq(`OP_AND, `SZ_WORD, 3'b000, a, b, nil), a & b, good);
    run(rq(`OP_OR, `SZ_WORD, 3'b000, a, b, nil), a | b, good);
    run(rq(`OP_XOR, `SZ_WORD, 3'b000, a, b, nil), a ^ b, good);
    run(rq(`OP_ANDC, `SZ_WORD, 3'b000, a, b, nil), a & ~b, good);
    run(rq(`OP_NOR, `SZ_WORD, 3'b000, a, b, nil), ~(a | b), good);
  endtask : t_logic

  task automatic t_shift();
    run(rq(`OP_RL, `SZ_BYTE, 3'b000, rb(8'h81), rb(8'h09), nil), rb(8'h03), good);
    run(rq(`OP_SL, `SZ_BYTE, 3'b000, rb(8'h81), rb(8'h09), nil), rb(8'h02), good);
    run(rq(`OP_SR, `SZ_BYTE, 3'b000, rb(8'h81), rb(8'h09), nil), rb(8'h40), good);
    run(rq(`OP_SRA, `SZ_BYTE, 3'b000, rb(8'h81), rb(8'h09), nil), rb(8'hc0), good);
    run(rq(`OP_RL, `SZ_WORD, 3'b000, rw(32'h8000_0001), rw(32'hffff_ffe4), nil),
        rw(32'h18), good);
  endtask : t_shift

  task automatic t_minmax();
    run(rq(`OP_MAX, `SZ_BYTE, 3'b000, rb(8'h80), rb(8'h01), nil), rb(8'h01), good);
    run(rq(`OP_MAX, `SZ_BYTE, 3'b100, rb(8'h80), rb(8'h01), nil), rb(8'h80), good);
    run(rq(`OP_MIN, `SZ_HALF, 3'b000, rh(16'h8000), rh(16'h1), nil), rh(16'h8000), good);
    run(rq(`OP_AVG, `SZ_BYTE, 3'b000, rb(8'h80), rb(8'h01), nil), rb(8'hc1), good);
    run(rq(`OP_AVG, `SZ_WORD, 3'b100, ~nil, rw(32'h1), nil), rw(32'h8000_0000), good);
  endtask : t_minmax

  task automatic t_mul();
    logic [127:0] a;
    a = {4{16'h3, 16'h5}};
    run(rq(`OP_MULE, `SZ_HALF, 3'b100, a, rh(16'h2), nil), rw(32'h6), good);
    run(rq(`OP_MULO, `SZ_HALF, 3'b100, a, rh(16'h2), nil), rw(32'ha), good);
    le_mode = 1'b1;
    run(rq(`OP_MULE, `SZ_HALF, 3'b100, a, rh(16'h2), nil), rw(32'ha), good);
    le_mode = 1'b0;
    run(rq(`OP_MULO, `SZ_BYTE, 3'b000, rb(8'hff), rb(8'h02), nil), rh(16'hfffe), good);
    run(rq(`OP_MULO, `SZ_BYTE, 3'b100, rb(8'hff), rb(8'h02), nil), rh(16'h01fe), good);
  endtask : t_mul

  task automatic t_madd();
    run(rq(`OP_MHADD, `SZ_HALF, 3'b000, rh(16'h1), rh(16'h4000), rh(16'h10)),
        rh(16'h10), good);
    run(rq(`OP_MHRADD, `SZ_HALF, 3'b000, rh(16'h1), rh(16'h4000), rh(16'h10)),
        rh(16'h11), good);
    run(rq(`OP_MHADD, `SZ_HALF, 3'b000, rh(16'h7fff), rh(16'h7fff), rh(16'h7fff)),
        rh(16'h7fff), good);
    run(rq(`OP_MHADD, `SZ_HALF, 3'b000, rh(16'h8000), rh(16'h7fff), rh(16'h8000)),
        rh(16'h8000), good);
    run(rq(`OP_MLADD, `SZ_HALF, 3'b100, rh(16'hffff), rh(16'h2), rh(16'h3)),
        rh(16'h1), good);
  endtask : t_madd

  task automatic t_msum();
    run(rq(`OP_MSUM, `SZ_BYTE, 3'b100, rb(8'h2), rb(8'h3), rw(32'h10)), rw(32'h28), good);
    run(rq(`OP_MSUM, `SZ_BYTE, 3'b000, rb(8'hff), rb(8'h3), rw(32'h10)), rw(32'h4), good);
    run(rq(`OP_MSUM, `SZ_HALF, 3'b010, rh(16'h7fff), rh(16'h7fff), rw(32'h7fff_ffff)),
        rw(32'h7fff_ffff), good);
    run(rq(`OP_MSUM, `SZ_HALF, 3'b000, rh(16'h7fff), rh(16'h7fff), rw(32'h7fff_ffff)),
        rw(32'hfffe_0001), good);
    run(rq(`OP_MSUM, `SZ_HALF, 3'b110, ~nil, ~nil, ~nil), ~nil, good);
  endtask : t_msum

  task automatic t_sum();
    run(rq(`OP_SUMS, `SZ_WORD, 3'b000, rw(32'h1), rw(32'h5), nil), {96'h0, 32'h9}, good);
    run(rq(`OP_SUMS, `SZ_WORD, 3'b000, rw(32'h7fff_ffff), rw(32'h7fff_ffff), nil),
        {96'h0, 32'h7fff_ffff}, good);
    run(rq(`OP_SUM2S, `SZ_WORD, 3'b000, rw(32'h1), rw(32'h2), nil),
        {2{32'h0, 32'h4}}, good);
    run(rq(`OP_SUM4S, `SZ_BYTE, 3'b100, ~nil, nil, nil), rw(32'h3fc), good);
    run(rq(`OP_SUM4S, `SZ_BYTE, 3'b000, rb(8'h80), rw(32'h7fff_ffff), nil),
        rw(32'h7fff_fdff), good);
    run(rq(`OP_SUM4S, `SZ_HALF, 3'b000, ~nil, nil, nil), rw(32'hffff_fffe), good);
  endtask : t_sum

  task automatic t_refuse();
    vec_req_type r;
    r = rq(`OP_ADD, `SZ_BYTE, 3'b100, nil, nil, nil);
    r.addr_lo = 2'h2;
    run(r, nil, bad);
    run(rq(`OP_ADD, 2'h3, 3'b100, nil, nil, nil), nil, bad);
    run(rq(5'h1b, `SZ_BYTE, 3'b100, nil, nil, nil), nil, bad);
  endtask : t_refuse

  initial begin
    repeat (6) @(posedge clock_i);
    #1;
    check(ready === 1'b1 && wb.valid === 1'b0 && fault === 1'b0, "reset outputs");
    rst_b_i = 1'b1;
    t_arith();
    t_cmp();
    t_logic();
    t_shift();
    t_minmax();
    t_mul();
    t_madd();
    t_msum();
    t_sum();
    t_refuse();
    wrap_up();
  end

endmodule : vector_integer_alu_tb
